// ===== fso_security.sv
`timescale 1ns/10ps
`default_nettype none

module fso_security (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [fso_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [fso_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] nv_option_i,
	input wire logic [63:0] stored_key_i,
	input wire fso_pkg::fso_mem_wr_s mem_wr_i,
	input wire logic blank_ok_i,
	input wire logic dbg_req_i,
	output logic dbg_grant_o,
	input wire logic spi_req_i,
	input wire logic [15:0] spi_addr_i,
	output logic spi_grant_o,
	output logic spi_error_o,
	output logic secured_o,
	output logic redirect_enable_o,
	output logic cmd_start_o
);
	import fso_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] option_reg;
	logic [7:0] option_next;
	logic loaded_reg;
	logic [7:0] config_reg;
	logic [7:0] config_next;
	logic cmd_start_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic key_match_w;

	// ----------------------------------------------------------------
	// option field decode
	// ----------------------------------------------------------------
	wire backdoor_enable_w = option_reg[BACKDOOR_ENABLE_BIT];
	wire redirect_disable_w = option_reg[REDIRECT_DISABLE_BIT];
	wire [1:0] security_code_w = option_reg[SECURITY_CODE_LSB +: 2];
	wire secured_w = (security_code_w != SEC_UNSECURED);
	wire key_write_enable_w = config_reg[KEY_WRITE_ENABLE_BIT];

	// ----------------------------------------------------------------
	// backdoor key comparison
	// ----------------------------------------------------------------
	fso_key_cmp u_key_cmp (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.wr_i(mem_wr_i),
		.capture_i(key_write_enable_w),
		.enable_i(backdoor_enable_w),
		.stored_key_i(stored_key_i),
		.match_o(key_match_w)
	);

	// ----------------------------------------------------------------
	// option register load and unlock
	// ----------------------------------------------------------------
	// the async reset can only place a constant, so the shadow holds the
	// erased (secured) pattern until the first edge after release copies
	// the flash byte; nothing is unsecured before that copy lands
	wire unlock_w = loaded_reg && (key_match_w || blank_ok_i);

	assign option_next = !loaded_reg ? (nv_option_i & OPTION_USED_MASK) :
		unlock_w ? {option_reg[7:2], SEC_UNSECURED} :
		option_reg;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			option_reg <= OPTION_RESET;
			loaded_reg <= 1'b0;
		end else begin
			option_reg <= option_next;
			loaded_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// flash command start on key addresses
	// ----------------------------------------------------------------
	wire key_addr_wr_w = mem_wr_i.wr && in_key_range(mem_wr_i.addr);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_start_reg <= 1'b0;
		end else begin
			cmd_start_reg <= key_addr_wr_w && !key_write_enable_w;
		end
	end

	assign cmd_start_o = cmd_start_reg;

	// ----------------------------------------------------------------
	// access control
	// ----------------------------------------------------------------
	wire spi_in_window_w = ((spi_addr_i >= SPI_WIN0_LO) && (spi_addr_i <= SPI_WIN0_HI))
		|| ((spi_addr_i >= SPI_WIN1_LO) && (spi_addr_i <= SPI_WIN1_HI));
	wire spi_allowed_w = !secured_w || spi_in_window_w;

	assign dbg_grant_o = dbg_req_i && !secured_w;
	assign spi_grant_o = spi_req_i && spi_allowed_w;
	assign spi_error_o = spi_req_i && !spi_allowed_w;
	assign secured_o = secured_w;
	assign redirect_enable_o = !redirect_disable_w;

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	// address and data are taken together, so one waits for the other
	wire wr_take_w = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_reg;
	wire wr_option_w = idx_hit(s_axi_awaddr_i, OPTION_SHADOW_IDX);
	wire wr_config_w = idx_hit(s_axi_awaddr_i, FLASH_CONFIG_IDX);
	wire wr_option_nonvolatile_w = idx_hit(s_axi_awaddr_i, OPTION_NONVOLATILE_IDX);
	wire wr_mapped_w = wr_option_w || wr_config_w || wr_option_nonvolatile_w;

	assign s_axi_awready_o = wr_take_w;
	assign s_axi_wready_o = wr_take_w;

	// writes to either option register are accepted and dropped
	assign config_next = (wr_take_w && wr_config_w && s_axi_wstrb_i[0]) ?
		(s_axi_wdata_i[7:0] & FLASH_CONFIG_MASK) : config_reg;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			config_reg <= FLASH_CONFIG_RESET;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			config_reg <= config_next;
			if (wr_take_w) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped_w ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	wire rd_take_w = s_axi_arvalid_i && !rvalid_reg;
	wire rd_option_w = idx_hit(s_axi_araddr_i, OPTION_SHADOW_IDX);
	wire rd_config_w = idx_hit(s_axi_araddr_i, FLASH_CONFIG_IDX);
	wire rd_option_nonvolatile_w = idx_hit(s_axi_araddr_i, OPTION_NONVOLATILE_IDX);
	wire rd_mapped_w = rd_option_w || rd_config_w || rd_option_nonvolatile_w;
	wire [7:0] rd_byte_w = rd_option_w ? option_reg :
		rd_config_w ? config_reg :
		rd_option_nonvolatile_w ? (nv_option_i & OPTION_USED_MASK) : 8'h00;

	assign s_axi_arready_o = rd_take_w;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			if (rd_take_w) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= rd_mapped_w ? RESP_OKAY : RESP_SLVERR;
				rdata_reg <= {24'h00_0000, rd_byte_w};
			end else if (s_axi_rready_i) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign s_axi_rdata_o = rdata_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence key_cmd_wr_s;
		mem_wr_i.wr && in_key_range(mem_wr_i.addr) && !key_write_enable_w;
	endsequence

	sequence option_wr_s;
		wr_take_w && (wr_option_w || wr_option_nonvolatile_w) && !unlock_w;
	endsequence

	unused_bits_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		option_reg[5:2] == 4'h0)
		else $error("unused option bits not zero");

	option_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(loaded_reg && !$past(loaded_reg)) |-> (option_reg == ($past(nv_option_i) & 8'hc3)))
		else $error("option shadow not loaded from flash byte");

	option_write_ignored_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(option_wr_s and loaded_reg) |=> (option_reg == $past(option_reg)))
		else $error("write changed the option shadow");

	no_backdoor_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!backdoor_enable_w |-> !key_match_w)
		else $error("key matched with backdoor disabled");

	unlock_code_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		unlock_w |=> (security_code_w == 2'h2) && !secured_o)
		else $error("unlock did not give unsecured code");

	redirect_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		redirect_enable_o == !option_reg[6])
		else $error("redirection does not follow option bit");

	secure_decode_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		secured_o == (option_reg[1:0] != 2'h2))
		else $error("security code decoded wrongly");

	debug_blocked_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		secured_o |-> !dbg_grant_o)
		else $error("debug granted while secured");

	spi_window_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(spi_req_i && secured_o && (spi_addr_i > 16'h008f) && (spi_addr_i < 16'h1800))
		|-> (spi_error_o && !spi_grant_o))
		else $error("secured serial access outside window not blocked");

	cmd_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		key_cmd_wr_s |=> cmd_start_o)
		else $error("key address write did not start a command");

	config_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(config_reg & 8'hdf) == 8'h00)
		else $error("unimplemented config bits set");

	sequence option_rd_s;
		s_axi_arvalid_i && s_axi_arready_o && rd_option_w;
	endsequence

	sequence config_wr_s;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && wr_config_w
			&& s_axi_wstrb_i[0];
	endsequence

	option_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		option_rd_s |=> (s_axi_rdata_o == {24'h00_0000, $past(option_reg)})
			&& (s_axi_rdata_o[5:2] == 4'h0))
		else $error("option shadow read returned wrong value");

	config_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		config_wr_s |=> (config_reg == ($past(s_axi_wdata_i[7:0]) & FLASH_CONFIG_MASK)))
		else $error("config write did not keep only the key-write bit");

	key_mode_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(mem_wr_i.wr && in_key_range(mem_wr_i.addr) && key_write_enable_w) |=> !cmd_start_o)
		else $error("comparison byte started a flash command");

	spi_window_open_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(spi_req_i && ((spi_addr_i <= SPI_WIN0_HI) || ((spi_addr_i >= SPI_WIN1_LO)
			&& (spi_addr_i <= SPI_WIN1_HI)))) |-> (spi_grant_o && !spi_error_o))
		else $error("serial access inside window refused");

	spi_high_blocked_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(spi_req_i && secured_o && (spi_addr_i > SPI_WIN1_HI)) |-> (spi_error_o && !spi_grant_o))
		else $error("secured serial access above window not blocked");

	unlock_held_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!secured_o |=> !secured_o)
		else $error("security came back without a reset");

	mismatch_locked_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(loaded_reg && secured_o && !key_match_w && !blank_ok_i) |=> secured_o)
		else $error("security released without match or blank check");

endmodule

`default_nettype wire

// ===== fso_pkg.sv
`default_nettype none

package fso_pkg;

	// ----------------------------------------------------------------
	// register map: printed offsets are indices, byte address = 4 * index
	// ----------------------------------------------------------------
	localparam logic [15:0] OPTION_SHADOW_IDX = 16'h1821;
	localparam logic [15:0] FLASH_CONFIG_IDX = 16'h1823;
	localparam logic [15:0] OPTION_NONVOLATILE_IDX = 16'hffbf;
	localparam int AXI_ADDR_W = 18;

	// ----------------------------------------------------------------
	// option register fields
	// ----------------------------------------------------------------
	localparam int BACKDOOR_ENABLE_BIT = 7;
	localparam int REDIRECT_DISABLE_BIT = 6;
	localparam int SECURITY_CODE_LSB = 0;
	localparam logic [7:0] OPTION_USED_MASK = 8'hc3;
	localparam logic [7:0] OPTION_RESET = 8'hc3;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;

	// ----------------------------------------------------------------
	// configuration register fields
	// ----------------------------------------------------------------
	localparam int KEY_WRITE_ENABLE_BIT = 5;
	localparam logic [7:0] FLASH_CONFIG_MASK = 8'h20;
	localparam logic [7:0] FLASH_CONFIG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// cpu address map
	// ----------------------------------------------------------------
	localparam logic [15:0] KEY_FIRST_ADDR = 16'hffb0;
	localparam logic [15:0] KEY_LAST_ADDR = 16'hffb7;
	localparam logic [15:0] SPI_WIN0_LO = 16'h0000;
	localparam logic [15:0] SPI_WIN0_HI = 16'h008f;
	localparam logic [15:0] SPI_WIN1_LO = 16'h1800;
	localparam logic [15:0] SPI_WIN1_HI = 16'h188f;

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// cpu-side memory write as seen by the flash controller
	typedef struct packed {
		logic wr;
		logic dbg;
		logic [15:0] addr;
		logic [7:0] data;
	} fso_mem_wr_s;

	function automatic logic in_key_range(input logic [15:0] addr);
		in_key_range = (addr >= KEY_FIRST_ADDR) && (addr <= KEY_LAST_ADDR);
	endfunction

	function automatic logic idx_hit(input logic [AXI_ADDR_W-1:0] addr, input logic [15:0] idx);
		idx_hit = (addr[AXI_ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

endpackage

`default_nettype wire

// ===== fso_key_cmp.sv
`timescale 1ns/10ps
`default_nettype none

module fso_key_cmp (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire fso_pkg::fso_mem_wr_s wr_i,
	input wire logic capture_i,
	input wire logic enable_i,
	input wire logic [63:0] stored_key_i,
	output logic match_o
);
	import fso_pkg::*;

	logic [2:0] index_reg;
	logic [2:0] index_next;
	logic good_reg;
	logic good_next;
	logic match_reg;
	logic match_next;

	// ----------------------------------------------------------------
	// comparison byte capture
	// ----------------------------------------------------------------
	wire key_write_w = wr_i.wr && !wr_i.dbg && capture_i && in_key_range(wr_i.addr);
	wire [2:0] byte_sel_w = wr_i.addr[2:0];
	wire in_order_w = (byte_sel_w == index_reg);
	wire byte_ok_w = (wr_i.data == stored_key_i[{byte_sel_w, 3'h0} +: 8]);
	wire run_ok_w = ((index_reg == 3'h0) || good_reg) && byte_ok_w;

	// an out-of-order byte restarts the sequence; byte 0 may open a new one
	assign index_next = !key_write_w ? index_reg :
		in_order_w ? 3'(index_reg + 3'h1) :
		(byte_sel_w == 3'h0) ? 3'h1 : 3'h0;
	assign good_next = !key_write_w ? good_reg :
		in_order_w ? run_ok_w :
		(byte_sel_w == 3'h0) ? byte_ok_w : 1'b0;
	// a mismatch yields no pulse, so security simply stays as it was
	assign match_next = key_write_w && in_order_w && (index_reg == 3'h7) && run_ok_w
		&& enable_i;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			index_reg <= 3'h0;
			good_reg <= 1'b0;
			match_reg <= 1'b0;
		end else begin
			index_reg <= index_next;
			good_reg <= good_next;
			match_reg <= match_next;
		end
	end

	assign match_o = match_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	debug_no_key_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_i.wr && wr_i.dbg) |-> ##1 (index_reg == $past(index_reg)))
		else $error("debug write moved the key sequence");

endmodule

`default_nettype wire

// ===== fso_security_tb.sv
`timescale 1ns/10ps
`default_nettype none

module fso_security_tb;
	import fso_pkg::*;
	logic mclk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, blank_ok, dbg_req, dbg_grant, spi_req, spi_grant, spi_error;
	logic secured, redir, cmd_start;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_val;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] nv_option, v;
	logic [63:0] key;
	logic [15:0] spi_addr;
	fso_mem_wr_s mem_wr;
	int n_errors, tests_run;

	fso_security dut (.mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .nv_option_i(nv_option), .stored_key_i(key),
		.mem_wr_i(mem_wr), .blank_ok_i(blank_ok), .dbg_req_i(dbg_req), .dbg_grant_o(dbg_grant),
		.spi_req_i(spi_req), .spi_addr_i(spi_addr), .spi_grant_o(spi_grant),
		.spi_error_o(spi_error), .secured_o(secured), .redirect_enable_o(redir),
		.cmd_start_o(cmd_start));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic spi_ok(input logic [15:0] a);
		return (a <= 16'h008f) || (a >= 16'h1800 && a <= 16'h188f);
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// bready is raised with the request and dropped once bvalid is seen; the trailing edge keeps the next call off this step
	task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge mclk_i); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge mclk_i); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk_i); while (!arready);
		arvalid <= 1'b0;
		do @(posedge mclk_i); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge mclk_i);
	endtask

	// new option byte takes effect only through a reset
	task automatic do_reset(input logic [7:0] nv);
		rst_i <= 1'b1;
		nv_option <= nv;
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask

	task automatic key_seq(input logic from_dbg, input logic [63:0] val);
		for (int n = 0; n < 8; n++) begin
			mem_wr <= '{wr: 1'b1, dbg: from_dbg, addr: KEY_FIRST_ADDR + 16'(n), data: val[8*n +: 8]};
			@(posedge mclk_i);
		end
		mem_wr <= '0;
		repeat (3) @(posedge mclk_i);
	endtask

	task automatic one_key_wr(input logic [15:0] a);
		mem_wr <= '{wr: 1'b1, dbg: 1'b0, addr: a, data: 8'h5a};
		@(posedge mclk_i);
		mem_wr <= '0;
		@(posedge mclk_i);
	endtask

	task automatic spi_chk(input logic [15:0] a, input logic sec);
		spi_req <= 1'b1;
		spi_addr <= a;
		@(posedge mclk_i);
		chk("spi_grant", spi_grant, !sec || spi_ok(a));
		chk("spi_error", spi_error, sec && !spi_ok(a));
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, blank_ok, spi_req} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		nv_option = 8'hff;
		mem_wr = '0;
		dbg_req = 1'b1;
		spi_addr = '0;
		n_errors = 0;
		tests_run = 0;
		void'($urandom(32'h1b5351f5));
		key = {$urandom, $urandom};
		for (int c = 0; c < 4; c++) begin
			v = 8'($urandom);
			v[1:0] = 2'(c);
			do_reset(v);
			axi_rd(OPTION_SHADOW_IDX, rd_val, rsp);
			chk("option_shadow", rd_val, {24'h0, v & 8'hc3});
			chk("secured", secured, v[1:0] != 2'b10);
			chk("redirect", redir, !v[6]);
			chk("dbg_grant", dbg_grant, v[1:0] == 2'b10);
		end
		$display("test option load done");
		do_reset(8'h40);
		axi_wr(OPTION_SHADOW_IDX, 32'hff, rsp);
		chk("shadow write resp", rsp, RESP_OKAY);
		axi_wr(OPTION_NONVOLATILE_IDX, 32'h82, rsp);
		axi_rd(OPTION_SHADOW_IDX, rd_val, rsp);
		chk("shadow after write", rd_val, 32'h40);
		chk("secured after write", secured, 1'b1);
		axi_wr(16'h1822, 32'h1, rsp);
		chk("unmapped write", rsp, RESP_SLVERR);
		axi_rd(16'h1822, rd_val, rsp);
		chk("unmapped read", {rd_val[1:0], rsp}, {2'h0, RESP_SLVERR});
		axi_rd(FLASH_CONFIG_IDX, rd_val, rsp);
		chk("config reset", rd_val, 32'h0);
		axi_wr(FLASH_CONFIG_IDX, 32'hff, rsp);
		axi_rd(FLASH_CONFIG_IDX, rd_val, rsp);
		chk("config bits", rd_val, 32'h20);
		for (int i = 0; i < 16; i++) begin
			spi_chk((i < 8) ? 16'(({16'h008f, 16'h0090, 16'h17ff, 16'h1800,
				16'h188f, 16'h1890, 16'h0000, 16'hffff} >> (16 * i))) : 16'($urandom), 1'b1);
		end
		key_seq(1'b0, key);
		chk("secured, backdoor off", secured, 1'b1);
		$display("test register access done");
		do_reset(8'hc0);
		one_key_wr(KEY_FIRST_ADDR + 16'h3);
		chk("cmd_start pulse", cmd_start, 1'b1);
		@(posedge mclk_i);
		chk("cmd_start width", cmd_start, 1'b0);
		axi_wr(FLASH_CONFIG_IDX, 32'h20, rsp);
		one_key_wr(KEY_LAST_ADDR);
		chk("cmd_start key mode", cmd_start, 1'b0);
		key_seq(1'b1, key);
		chk("secured, debug key", secured, 1'b1);
		key_seq(1'b0, key ^ (64'h1 << (8 * $urandom_range(0, 7))));
		chk("secured, bad key", secured, 1'b1);
		key_seq(1'b0, key);
		chk("secured, good key", secured, 1'b0);
		axi_rd(OPTION_SHADOW_IDX, rd_val, rsp);
		chk("code after key", rd_val[1:0], 2'b10);
		chk("dbg_grant open", dbg_grant, 1'b1);
		dbg_req <= 1'b0;
		@(posedge mclk_i);
		chk("dbg_grant idle", dbg_grant, 1'b0);
		dbg_req <= 1'b1;
		spi_chk(16'hffff, 1'b0);
		$display("test backdoor key done");
		do_reset(8'h03);
		chk("secured after reset", secured, 1'b1);
		blank_ok <= 1'b1;
		@(posedge mclk_i);
		blank_ok <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk("secured, blank ok", secured, 1'b0);
		$display("test blank check done");
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		complete_run();
	end
endmodule

`default_nettype wire
